/* File: pci_target_interface_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin failures++; \
  $display("unexpected %s: expected %h seen %h", nm, ex, gt); end end
module pci_target_interface_tb;
  import ptif_pkg::*;

  logic        core_clk, nrst, req, req_idsel, irq_req, ab;
  logic [3:0]  req_cmd, req_be_n, wbe;
  logic [31:0] req_addr, req_wdata, rd, wdat;
  logic [7:0]  wa;
  logic        busy_q, done_q, abort_q, wr_stb_q, par_err_q, fpe;
  logic [31:0] rdata_q, wr_data_q;
  logic [7:0]  wr_addr_q;
  logic [3:0]  wr_be_q;
  int          failures = 0;
  int          checked = 0;
  logic [3:0]  rcmds [3] = '{PTIF_CMD_MEM_RD, PTIF_CMD_MEM_RD_MULT, PTIF_CMD_MEM_RD_LINE};
  logic [3:0]  ucmds [3] = '{4'h2, 4'h3, PTIF_CMD_SPECIAL};

  ptif_bus_if ptif_bus_if_inst ();
  // second bus: the bench plays a faulty master here
  ptif_bus_if fault_bus ();

  ptif_target ptif_target_inst (.core_clk, .nrst, .bus(ptif_bus_if_inst.target), .irq_req,
    .wr_stb_q, .wr_addr_q, .wr_data_q, .wr_be_q, .par_err_q);
  ptif_target ptif_target_fault_inst (.core_clk, .nrst, .bus(fault_bus.target),
    .irq_req(1'b0), .wr_stb_q(), .wr_addr_q(), .wr_data_q(), .wr_be_q(), .par_err_q(fpe));
  ptif_master ptif_master_inst (.core_clk, .nrst, .bus(ptif_bus_if_inst.master), .req,
    .req_cmd, .req_addr, .req_wdata, .req_be_n, .req_idsel, .busy_q, .done_q, .abort_q,
    .rdata_q);
  ptif_bus_assertions ptif_bus_assertions_inst (.core_clk, .nrst,
    .ad(ptif_bus_if_inst.ad), .par(ptif_bus_if_inst.par), .cbe_n(ptif_bus_if_inst.cbe_n),
    .frame_n(ptif_bus_if_inst.frame_n), .irdy_n(ptif_bus_if_inst.irdy_n),
    .idsel(ptif_bus_if_inst.idsel), .trdy_n(ptif_bus_if_inst.trdy_n),
    .stop_n(ptif_bus_if_inst.stop_n), .devsel_n(ptif_bus_if_inst.devsel_n),
    .t_ad_oe(ptif_bus_if_inst.t_ad_oe), .t_par_oe(ptif_bus_if_inst.t_par_oe));

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // whole run is under two hundred cycles; this is ample margin
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    close_out();
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  // one transfer through the master; req dropped once it goes busy
  task automatic op(input logic [3:0] cmd, input logic [31:0] addr, input logic [31:0] wd,
                    input logic [3:0] be_n, input logic sel);
    int n;
    @(negedge core_clk);
    req       = 1'b1;
    req_cmd   = cmd;
    req_addr  = addr;
    req_wdata = wd;
    req_be_n  = be_n;
    req_idsel = sel;
    n = 0;
    while (busy_q !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    req = 1'b0;
    while (done_q !== 1'b1 && abort_q !== 1'b1 && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    ab = abort_q;
    rd = rdata_q;
    // write strobe rises on the same edge as done, so take it here
    if (wr_stb_q === 1'b1)
    begin
      wa   = wr_addr_q;
      wdat = wr_data_q;
      wbe  = wr_be_q;
    end
    `CHK("op finished", 1'b1, n < 60)
  endtask : op

  // single-word write on the second bus with chosen parity faults
  task automatic fault(input logic bad_a, input logic bad_d);
    int n;
    int pl;
    int hi;
    logic sl;
    logic pe;
    @(negedge core_clk);
    fault_bus.frame_n = 1'b0;
    fault_bus.m_ad_oe = 1'b1;
    fault_bus.m_ad_o  = 32'h0000_0020;
    fault_bus.cbe_n   = PTIF_CMD_MEM_WR;
    @(negedge core_clk);
    fault_bus.m_par_oe = 1'b1;
    fault_bus.m_par_o  = ^{32'h0000_0020, PTIF_CMD_MEM_WR} ^ bad_a;
    fault_bus.m_ad_o   = 32'hC3C3_0F0F;
    fault_bus.cbe_n    = 4'h0;
    fault_bus.irdy_n   = 1'b0;
    fault_bus.frame_n  = 1'b1;
    n  = 0;
    pl = -1;
    hi = 0;
    sl = 1'b0;
    pe = 1'b0;
    while (fault_bus.trdy_n !== 1'b0 && n < 8)
    begin
      @(negedge core_clk);
      n++;
    end
    for (int k = 0; k < 12; k++)
    begin
      @(negedge core_clk);
      if (k == 0)
      begin
        fault_bus.irdy_n  = 1'b1;
        fault_bus.m_ad_oe = 1'b0;
        fault_bus.cbe_n   = 4'hF;
        fault_bus.m_par_o = ^{32'hC3C3_0F0F, 4'h0} ^ bad_d;
      end
      if (k == 1)
        fault_bus.m_par_oe = 1'b0;
      if (fault_bus.perr_n === 1'b0 && pl < 0)
        pl = k;
      if (pl >= 0 && fault_bus.perr_n === 1'b1 && fault_bus.perr_oe === 1'b1)
        hi++;
      if (fault_bus.serr_n === 1'b0)
        sl = 1'b1;
      if (fpe === 1'b1)
        pe = 1'b1;
    end
    `CHK("perr seen", bad_d, pl >= 0)
    `CHK("par err flag", bad_d, pe)
    if (bad_d)
    begin
      `CHK("perr delay", 1'b1, pl == 2)
      `CHK("perr high", 2, hi)
    end
    `CHK("serr seen", bad_a, sl)
  endtask : fault

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    nrst      = 1'b0;
    req       = 1'b0;
    req_cmd   = 4'h0;
    req_addr  = 32'h0000_0000;
    req_wdata = 32'h0000_0000;
    req_be_n  = 4'hF;
    req_idsel = 1'b0;
    irq_req   = 1'b0;
    fault_bus.frame_n  = 1'b1;
    fault_bus.irdy_n   = 1'b1;
    fault_bus.idsel    = 1'b0;
    fault_bus.cbe_n    = 4'hF;
    fault_bus.m_ad_o   = 32'h0000_0000;
    fault_bus.m_ad_oe  = 1'b0;
    fault_bus.m_par_o  = 1'b0;
    fault_bus.m_par_oe = 1'b0;
    repeat (16) @(negedge core_clk);
    nrst = 1'b1;
    `CHK("inta idle", 1'b1, ptif_bus_if_inst.inta_n)
    `CHK("devsel idle", 1'b1, ptif_bus_if_inst.devsel_n)
    op(PTIF_CMD_MEM_WR, 32'h0000_0040, 32'hA5A5_1234, 4'h0, 1'b0);
    `CHK("wr abort", 1'b0, ab)
    `CHK("wr addr", 8'h10, wa)
    `CHK("wr data", 32'hA5A5_1234, wdat)
    `CHK("wr be", 4'hF, wbe)
    op(PTIF_CMD_MEM_WR, 32'h0000_0040, 32'h1111_2222, 4'hA, 1'b0);
    `CHK("be map", 4'h5, wbe)
    op(PTIF_CMD_MEM_RD, 32'h0000_0040, 32'h0000_0000, 4'h0, 1'b0);
    `CHK("rd merge", 32'hA511_1222, rd)
    $display("test memory done");
    op(PTIF_CMD_MEM_WR_INV, 32'h0000_0080, 32'h5A5A_C3C3, 4'h0, 1'b0);
    `CHK("inv addr", 8'h20, wa)
    foreach (rcmds[i])
    begin
      op(rcmds[i], 32'h0000_0080, 32'h0000_0000, 4'h0, 1'b0);
      `CHK("alias rd", 32'h5A5A_C3C3, rd)
    end
    $display("test alias done");
    op(PTIF_CMD_CFG_WR, 32'h0000_0008, 32'h0F0F_7E7E, 4'h0, 1'b1);
    `CHK("cfg wr", 1'b0, ab)
    op(PTIF_CMD_CFG_RD, 32'h0000_0008, 32'h0000_0000, 4'h0, 1'b1);
    `CHK("cfg rd", 32'h0F0F_7E7E, rd)
    op(PTIF_CMD_CFG_RD, 32'h0000_0008, 32'h0000_0000, 4'h0, 1'b0);
    `CHK("cfg nosel", 1'b1, ab)
    $display("test config done");
    foreach (ucmds[i])
    begin
      op(ucmds[i], 32'h0000_0010, 32'h0000_0000, 4'h0, 1'b1);
      `CHK("unclaimed", 1'b1, ab)
    end
    op(PTIF_CMD_MEM_WR, 32'h0000_0400, 32'h0000_0000, 4'h0, 1'b0);
    `CHK("outside window", 1'b1, ab)
    $display("test refusal done");
    irq_req = 1'b1;
    repeat (2) @(negedge core_clk);
    `CHK("inta set", 1'b0, ptif_bus_if_inst.inta_n)
    irq_req = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("inta clear", 1'b1, ptif_bus_if_inst.inta_n)
    $display("test interrupt done");
    fault(1'b0, 1'b0);
    fault(1'b0, 1'b1);
    fault(1'b1, 1'b0);
    $display("test parity done");
    close_out();
  end
endmodule : pci_target_interface_tb

/* File: ptif_bus_assertions.sv */
`timescale 1ns/1ps
module ptif_bus_assertions
  import ptif_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [31:0] ad,
  input wire logic        par,
  input wire logic [3:0]  cbe_n,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic        idsel,
  input wire logic        trdy_n,
  input wire logic        stop_n,
  input wire logic        devsel_n,
  input wire logic        t_ad_oe,
  input wire logic        t_par_oe
);
  // ---------------------------------------------------------------
  // address-phase decode
  // ---------------------------------------------------------------
  logic frame_q;
  logic rd_q;
  logic start;
  logic mem_cmd;
  logic cfg_cmd;
  logic hit;

  // start of a transaction is frame newly low
  assign start   = frame_q & ~frame_n;
  assign mem_cmd = cbe_n inside {PTIF_CMD_MEM_RD, PTIF_CMD_MEM_WR, PTIF_CMD_MEM_RD_MULT,
                                 PTIF_CMD_MEM_RD_LINE, PTIF_CMD_MEM_WR_INV};
  assign cfg_cmd = cbe_n inside {PTIF_CMD_CFG_RD, PTIF_CMD_CFG_WR};
  assign hit     = (mem_cmd && ((ad & PTIF_MEM_MASK) == PTIF_MEM_BASE)) || (cfg_cmd && idsel);

  // direction kept so read checks skip writes; reads have bit 0 low
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      frame_q <= 1'b1;
      rd_q    <= 1'b0;
    end
    else
    begin
      frame_q <= frame_n;
      if (start)
        rd_q <= ~cbe_n[0];
    end
  end

  // ---------------------------------------------------------------
  // handshake properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  claim_timing_a: assert property (start && hit |=> !devsel_n && !trdy_n)
    else $error("own cycle not claimed one clock after address");
  unclaimed_cmd_a: assert property (start && !mem_cmd && !cfg_cmd |=> devsel_n [*4])
    else $error("unsupported command was claimed");
  cfg_select_a: assert property (start && cfg_cmd && !idsel |=> devsel_n [*4])
    else $error("configuration claimed without idsel");
  read_drive_a: assert property (!trdy_n && rd_q |-> t_ad_oe)
    else $error("target ready on read without driving data");
  read_parity_a: assert property (!trdy_n && !irdy_n && rd_q |=>
    t_par_oe && (par == ^{$past(ad), $past(cbe_n)}))
    else $error("read parity wrong or not driven");
  final_release_a: assert property (!trdy_n && !irdy_n && frame_n |=> trdy_n && devsel_n)
    else $error("target still ready after final transfer");
  ready_select_a: assert property (!trdy_n || !stop_n |-> !devsel_n)
    else $error("ready or stop without device select");
  bus_release_a: assert property ($rose(devsel_n) |=> !t_ad_oe && !t_par_oe)
    else $error("target still drives bus after cycle end");

  rd_cover: cover property (start && hit && !cbe_n[0]);
  xfer_cover: cover property (!trdy_n && !irdy_n);
  abort_cover: cover property (start && !hit);
endmodule : ptif_bus_assertions

/* File: ptif_bus_if.sv */
`timescale 1ns/1ps
interface ptif_bus_if;
  import ptif_pkg::*;

  // ---------------------------------------------------------------
  // shared bus lines; ad and par with per-end drive and enable
  // ---------------------------------------------------------------
  logic [31:0] m_ad_o;
  logic        m_ad_oe;
  logic [31:0] t_ad_o;
  logic        t_ad_oe;
  logic [3:0]  cbe_n;
  logic        m_par_o;
  logic        m_par_oe;
  logic        t_par_o;
  logic        t_par_oe;
  logic        frame_n;
  logic        irdy_n;
  logic        idsel;
  logic        t_ctl_oe;
  logic        trdy_n_o;
  logic        stop_n_o;
  logic        devsel_n_o;
  logic        perr_n_o;
  logic        perr_oe;
  logic        serr_n_o;
  logic        serr_oe;
  logic        inta_n;

  // resolved wire levels (pull-ups when nobody drives)
  logic [31:0] ad;
  logic        par;
  logic        trdy_n;
  logic        stop_n;
  logic        devsel_n;
  logic        perr_n;
  logic        serr_n;

  assign ad       = t_ad_oe ? t_ad_o : (m_ad_oe ? m_ad_o : 32'hFFFF_FFFF);
  assign par      = t_par_oe ? t_par_o : (m_par_oe ? m_par_o : 1'b1);
  assign trdy_n   = t_ctl_oe ? trdy_n_o : 1'b1;
  assign stop_n   = t_ctl_oe ? stop_n_o : 1'b1;
  assign devsel_n = t_ctl_oe ? devsel_n_o : 1'b1;
  assign perr_n   = perr_oe ? perr_n_o : 1'b1;
  assign serr_n   = serr_oe ? serr_n_o : 1'b1;

  modport target
  (
    input  ad, par, cbe_n, frame_n, irdy_n, idsel,
    output t_ad_o, t_ad_oe, t_par_o, t_par_oe, t_ctl_oe, trdy_n_o,
    output stop_n_o, devsel_n_o, perr_n_o, perr_oe, serr_n_o, serr_oe, inta_n
  );

  modport master
  (
    input  ad, par, trdy_n, stop_n, devsel_n, perr_n, serr_n, inta_n,
    output m_ad_o, m_ad_oe, m_par_o, m_par_oe, cbe_n, frame_n, irdy_n, idsel
  );

endinterface : ptif_bus_if

/* File: ptif_master.sv */
`timescale 1ns/1ps
// single-word master; one request at a time
module ptif_master
  import ptif_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  ptif_bus_if.master       bus,
  input  wire logic        req,
  input  wire logic [3:0]  req_cmd,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic [3:0]  req_be_n,
  input  wire logic        req_idsel,
  output logic             busy_q,
  output logic             done_q,
  output logic             abort_q,
  output logic [31:0]      rdata_q
);

  typedef enum {MS_IDLE, MS_ADDR, MS_DATA, MS_END} ptif_mstate_t;

  ptif_mstate_t state_q;
  logic [31:0]  ad_q;
  logic [3:0]   cbe_q;
  logic         ad_oe_q;
  logic         par_oe_q;
  logic         frame_q;
  logic         irdy_q;
  logic         idsel_q;
  logic         is_rd_q;
  logic [2:0]   wait_q;
  logic         par_q;
  logic         par_calc;

  ptif_parity u_par
  (
    .data (ad_q),
    .cbe  (cbe_q),
    .par  (par_calc)
  );

  // ---------------------------------------------------------------
  // address phase, one data phase, then release
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      state_q <= MS_IDLE;
      ad_q    <= 32'h0000_0000;
      cbe_q   <= 4'hF;
      ad_oe_q <= 1'b0;
      frame_q <= 1'b0;
      irdy_q  <= 1'b0;
      idsel_q <= 1'b0;
      is_rd_q <= 1'b0;
      wait_q  <= 3'd0;
      busy_q  <= 1'b0;
      done_q  <= 1'b0;
      abort_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      done_q  <= 1'b0;
      abort_q <= 1'b0;
      unique case (state_q)
        MS_IDLE:
          if (req)
          begin
            state_q <= MS_ADDR;
            ad_q    <= req_addr; // R4
            cbe_q   <= req_cmd;
            ad_oe_q <= 1'b1;
            frame_q <= 1'b1;
            idsel_q <= req_idsel;
            is_rd_q <= !req_cmd[0];
            busy_q  <= 1'b1;
          end
        MS_ADDR:
        begin
          state_q <= MS_DATA;
          frame_q <= 1'b0; // R5 single data phase is the last
          irdy_q  <= 1'b1; // R7
          cbe_q   <= req_be_n;
          ad_q    <= req_wdata;
          ad_oe_q <= !is_rd_q;
          wait_q  <= 3'd0;
        end
        MS_DATA:
        begin
          wait_q <= wait_q + 3'd1;
          if (!bus.trdy_n || !bus.stop_n || (wait_q == 3'd6 && bus.devsel_n)) // R6
          begin
            state_q <= MS_END;
            irdy_q  <= 1'b0;
            ad_oe_q <= 1'b0;
            rdata_q <= bus.ad;
            done_q  <= !bus.trdy_n;
            abort_q <= bus.trdy_n;
          end
        end
        MS_END:
        begin
          state_q <= MS_IDLE;
          busy_q  <= 1'b0;
          idsel_q <= 1'b0;
        end
      endcase
    end
  end

  // parity one clock behind what was driven
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      par_q    <= 1'b0;
      par_oe_q <= 1'b0;
    end
    else
    begin
      par_q    <= par_calc; // R9 R11
      par_oe_q <= ad_oe_q;
    end
  end

  assign bus.m_ad_o   = ad_q;
  assign bus.m_ad_oe  = ad_oe_q;
  assign bus.m_par_o  = par_q;
  assign bus.m_par_oe = par_oe_q;
  assign bus.cbe_n    = cbe_q;
  assign bus.frame_n  = !frame_q;
  assign bus.irdy_n   = !irdy_q;
  assign bus.idsel    = idsel_q;

endmodule : ptif_master

/* File: ptif_parity.sv */
`timescale 1ns/1ps
// even parity over 32 data bits and 4 command/enable bits
module ptif_parity
  import ptif_pkg::*;
(
  input  wire logic [31:0] data,
  input  wire logic [3:0]  cbe,
  output logic             par
);

  // ---------------------------------------------------------------
  // reduction xor
  // ---------------------------------------------------------------
  assign par = ^{data, cbe}; // R9

endmodule : ptif_parity

/* File: ptif_pkg.sv */
package ptif_pkg;

  // ---------------------------------------------------------------
  // bus commands (address-phase code on the command/enable lines)
  // ---------------------------------------------------------------
  localparam logic [3:0] PTIF_CMD_MEM_RD      = 4'h6;
  localparam logic [3:0] PTIF_CMD_MEM_WR      = 4'h7;
  localparam logic [3:0] PTIF_CMD_CFG_RD      = 4'hA;
  localparam logic [3:0] PTIF_CMD_CFG_WR      = 4'hB;
  localparam logic [3:0] PTIF_CMD_MEM_RD_MULT = 4'hC;
  localparam logic [3:0] PTIF_CMD_MEM_RD_LINE = 4'hE;
  localparam logic [3:0] PTIF_CMD_MEM_WR_INV  = 4'hF;
  localparam logic [3:0] PTIF_CMD_SPECIAL     = 4'h1;

  // ---------------------------------------------------------------
  // widths and timing counts
  // ---------------------------------------------------------------
  localparam int unsigned PTIF_AD_W          = 32;
  localparam int unsigned PTIF_BE_W          = 4;
  localparam int unsigned PTIF_MEM_AW        = 8;
  localparam int unsigned PTIF_MEM_DEPTH     = 256;
  localparam logic [1:0]  PTIF_PERR_DELAY    = 2'd2;
  localparam logic [1:0]  PTIF_PERR_HOLD     = 2'd2;
  localparam logic [3:0]  PTIF_BURST_LIMIT   = 4'h8;
  localparam logic [31:0] PTIF_MEM_BASE      = 32'h0000_0000;
  localparam logic [31:0] PTIF_MEM_MASK      = 32'hFFFF_FC00;
  localparam logic [31:0] PTIF_RST_DATA      = 32'h0000_0000;

  // ---------------------------------------------------------------
  // decoded access kinds
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    PTIF_ACC_NONE,
    PTIF_ACC_MEM,
    PTIF_ACC_CFG
  } ptif_acc_t;

endpackage : ptif_pkg

/* File: ptif_target.sv */
`timescale 1ns/1ps
// Overview of operation
// R1 - answer memory and configuration reads/writes
// R2 - read multiple/line and write-invalidate alias basics
// R3 - data-phase enables low-active, bit0 is byte0
// R4 - address and command captured on first frame
// R5 - master holds frame until last data phase
// R6 - word moves only when both readies low
// R7 - master ready means write data valid
// R8 - target ready with valid read data driven
// R9 - even parity over data and command lines
// R10 - target drives read parity one clock later
// R11 - master drives address and write parity later
// R12 - selected target drives stop to end transfer
// R13 - configuration accepted only with idsel high
// R14 - device select after own address decoded
// R15 - data parity error flagged two clocks later
// R16 - parity error line driven high two clocks
// R17 - system error on address or special parity; serr here on address parity only
// R18 - interrupt is low-active level, unclocked meaning
// R19 - bus sampled on rising edge, any rate
// R20 - one address phase then data phases
// R21 - target only, unknown commands left unclaimed
module ptif_target
  import ptif_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic nrst,
  ptif_bus_if.target bus,
  input  wire logic irq_req,
  output logic      wr_stb_q,
  output logic [7:0] wr_addr_q,
  output logic [31:0] wr_data_q,
  output logic [3:0] wr_be_q,
  output logic      par_err_q
);

  typedef enum {ST_IDLE, ST_DATA, ST_TURN} ptif_state_t;

  ptif_state_t state_q;
  logic        is_read_q;
  logic [7:0]  addr_q;
  logic [3:0]  beat_q;
  logic [7:0]  rd_idx;
  logic [31:0] rd_lane;
  logic [31:0] rd_data_q;
  logic        drive_q;
  logic        trdy_q;
  logic        stop_q;
  logic        chk_q;
  logic        addr_chk_q;
  logic [31:0] ad_prev_q;
  logic [3:0]  cbe_prev_q;
  logic [1:0]  perr_cnt_q;
  logic        perr_act_q;
  logic        perr_oe_q;
  logic        perr_q;
  logic        serr_q;
  logic        inta_q;
  logic        par_out_q;
  logic        par_oe_q;
  logic        calc_par;
  logic        xfer;
  ptif_acc_t   acc_d;
  logic        start;

  ptif_parity u_par
  (
    .data (ad_prev_q),
    .cbe  (cbe_prev_q),
    .par  (calc_par)
  );

  // ---------------------------------------------------------------
  // command decode on the first frame clock
  // ---------------------------------------------------------------
  assign start = (state_q == ST_IDLE) && !bus.frame_n; // R20
  always_comb
  begin
    acc_d = PTIF_ACC_NONE; // R21
    unique case (bus.cbe_n) // R1
      PTIF_CMD_MEM_RD, PTIF_CMD_MEM_WR, PTIF_CMD_MEM_RD_MULT,
      PTIF_CMD_MEM_RD_LINE, PTIF_CMD_MEM_WR_INV: // R2
        if ((bus.ad & PTIF_MEM_MASK) == PTIF_MEM_BASE)
          acc_d = PTIF_ACC_MEM;
      PTIF_CMD_CFG_RD, PTIF_CMD_CFG_WR:
        if (bus.idsel)
          acc_d = PTIF_ACC_CFG; // R13
      default:
        acc_d = PTIF_ACC_NONE;
    endcase
  end

  assign xfer = trdy_q && !bus.irdy_n; // R6

  // ---------------------------------------------------------------
  // transaction state, claim and ready handshake
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) // R19
  begin
    if (!nrst)
    begin
      state_q   <= ST_IDLE;
      is_read_q <= 1'b0;
      addr_q    <= 8'h00;
      beat_q    <= 4'h0;
      trdy_q    <= 1'b0;
      stop_q    <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE:
          if (start && acc_d != PTIF_ACC_NONE)
          begin
            state_q   <= ST_DATA; // R14
            is_read_q <= !bus.cbe_n[0]; // R4
            addr_q    <= bus.ad[9:2]; // R4
            beat_q    <= 4'h0;
            trdy_q    <= 1'b1; // R8
          end
        ST_DATA:
        begin
          if (xfer)
          begin
            addr_q <= addr_q + 8'h01;
            beat_q <= beat_q + 4'h1;
            if (beat_q + 4'h1 == PTIF_BURST_LIMIT)
              stop_q <= 1'b1; // R12
          end
          if (xfer && bus.frame_n) // R5
          begin
            state_q <= ST_TURN;
            trdy_q  <= 1'b0;
            stop_q  <= 1'b0;
          end
          else if (stop_q && bus.frame_n)
          begin
            state_q <= ST_TURN;
            trdy_q  <= 1'b0;
            stop_q  <= 1'b0;
          end
          else if (stop_q || (xfer && beat_q + 4'h1 == PTIF_BURST_LIMIT))
            trdy_q <= 1'b0;
        end
        ST_TURN:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read data path; memory words used for both spaces
  // ---------------------------------------------------------------
  always_comb
  begin
    rd_idx = addr_q + 8'h01; // next word of a burst
    if (state_q == ST_IDLE)
      rd_idx = bus.ad[9:2];
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      rd_data_q <= PTIF_RST_DATA;
    else if (state_q == ST_IDLE || xfer)
      rd_data_q <= rd_lane; // R8
  end

  // write with byte enables, low active; each lane owns its storage
  // so that no two processes write one array
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++)
    begin : g_be
      logic [7:0] lane_q [PTIF_MEM_DEPTH];
      always_ff @(posedge core_clk)
      begin
        if (state_q == ST_DATA && xfer && !is_read_q && !bus.cbe_n[gb]) // R3 R7
          lane_q[addr_q] <= bus.ad[8*gb +: 8];
      end
      assign rd_lane[8*gb +: 8] = lane_q[rd_idx];
    end
  endgenerate

  // user-side write strobe
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wr_stb_q  <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= PTIF_RST_DATA;
      wr_be_q   <= 4'h0;
    end
    else
    begin
      wr_stb_q  <= state_q == ST_DATA && xfer && !is_read_q;
      wr_addr_q <= addr_q;
      wr_data_q <= bus.ad;
      wr_be_q   <= ~bus.cbe_n; // R3
    end
  end

  // ---------------------------------------------------------------
  // bus drive enables; read data only during read data phases
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      drive_q  <= 1'b0;
      par_oe_q <= 1'b0;
      par_out_q <= 1'b0;
    end
    else
    begin
      drive_q  <= (start && acc_d != PTIF_ACC_NONE && !bus.cbe_n[0])
                  || (state_q == ST_DATA && is_read_q && !(xfer && bus.frame_n)
                      && !(stop_q && bus.frame_n));
      par_oe_q  <= drive_q; // R10
      par_out_q <= ^{bus.t_ad_o, bus.cbe_n}; // R9 R10
    end
  end

  // ---------------------------------------------------------------
  // parity checking, one clock behind the sampled lines
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ad_prev_q  <= 32'h0000_0000;
      cbe_prev_q <= 4'h0;
      chk_q      <= 1'b0;
      addr_chk_q <= 1'b0;
    end
    else
    begin
      ad_prev_q  <= bus.ad;
      cbe_prev_q <= bus.cbe_n;
      addr_chk_q <= start; // R11
      chk_q      <= state_q == ST_DATA && xfer && !is_read_q; // R11
    end
  end

  // ---------------------------------------------------------------
  // error reporting: perr two clocks after data, serr on address
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      perr_cnt_q <= 2'd0;
      perr_act_q <= 1'b0;
      perr_q     <= 1'b0;
      perr_oe_q  <= 1'b0;
      serr_q     <= 1'b0;
      par_err_q  <= 1'b0;
    end
    else
    begin
      perr_act_q <= chk_q && (calc_par != bus.par); // detected one clock after data
      par_err_q  <= chk_q && (calc_par != bus.par);
      serr_q     <= addr_chk_q && (calc_par != bus.par); // R17
      if (perr_act_q)
      begin
        perr_q     <= 1'b1; // R15
        perr_oe_q  <= 1'b1;
        perr_cnt_q <= PTIF_PERR_HOLD;
      end
      else if (perr_q)
      begin
        perr_q     <= 1'b0; // high phase begins
        perr_cnt_q <= perr_cnt_q - 2'd1; // R16
      end
      else if (perr_cnt_q != 2'd0)
        perr_cnt_q <= perr_cnt_q - 2'd1; // R16
      else
        perr_oe_q <= 1'b0;
    end
  end

  // special cycles are never claimed, so only address parity reaches serr
  // interrupt level, registered to keep it glitch free
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      inta_q <= 1'b1;
    else
      inta_q <= !irq_req; // R18
  end

  // ---------------------------------------------------------------
  // bus outputs
  // ---------------------------------------------------------------
  assign bus.t_ad_o     = rd_data_q;
  assign bus.t_ad_oe    = drive_q;
  assign bus.t_par_o    = par_out_q;
  assign bus.t_par_oe   = par_oe_q;
  assign bus.t_ctl_oe   = state_q != ST_IDLE;
  assign bus.trdy_n_o   = !trdy_q;
  assign bus.stop_n_o   = !stop_q;
  assign bus.devsel_n_o = state_q != ST_DATA; // R14
  assign bus.perr_n_o   = !perr_q;
  assign bus.perr_oe    = perr_oe_q;
  assign bus.serr_n_o   = 1'b0;
  assign bus.serr_oe    = serr_q; // R17
  assign bus.inta_n     = inta_q;

endmodule : ptif_target
